// [shared/afm_pkg.sv]
// Package with constants and types for the front-end monitor control block
package afm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] AFM_OFS_PRI_SEL  = 8'h06;
  localparam logic [7:0] AFM_OFS_AUX_SEL  = 8'h16;
  localparam logic [7:0] AFM_OFS_GAIN_CFG = 8'h08;
  localparam logic [7:0] AFM_OFS_BIAS_CFG = 8'h09;
  localparam logic [7:0] AFM_OFS_STATUS   = 8'h0a;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] AFM_RST_PRI_SEL  = 8'h00;
  localparam logic [7:0] AFM_RST_AUX_SEL  = 8'h00;
  localparam logic [7:0] AFM_RST_GAIN_CFG = 8'h00;
  localparam logic [7:0] AFM_RST_BIAS_CFG = 8'h00;
  localparam logic [7:0] AFM_RST_STATUS   = 8'h00;
  localparam logic [7:0] AFM_RD_UNMAPPED  = 8'h00;
  localparam logic [7:0] AFM_RST_RD_DATA  = 8'h00;
  localparam logic [5:0] AFM_RST_AMP_GAIN = 6'h01;

  // ---------------------------------------------------------------
  // Input-select codes and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] AFM_SEL_TEMP     = 8'hbb;
  localparam logic [7:0] AFM_SEL_ANA_MON  = 8'hcc;
  localparam logic [7:0] AFM_SEL_DIG_MON  = 8'hdd;
  localparam int         AFM_POS_LSB      = 0;
  localparam int         AFM_NEG_LSB      = 4;

  // Gain configuration fields
  localparam int         AFM_GAIN_LSB     = 0;
  localparam logic [2:0] AFM_GAIN_LAST    = 3'h5;
  localparam int         AFM_BYPASS_BIT   = 7;
  localparam logic [7:0] AFM_GAIN_WR_MASK = 8'h87;

  // Bias configuration fields
  localparam int         AFM_BIAS_TGT_BIT = 0;
  localparam int         AFM_BIAS_POL_BIT = 1;
  localparam int         AFM_BIAS_MAG_LSB = 2;
  localparam logic [7:0] AFM_BIAS_WR_MASK = 8'h1f;

  // Status byte bit positions
  localparam int         AFM_STS_DIFF_BIT = 1;
  localparam int         AFM_STS_HIGH_BIT = 2;
  localparam int         AFM_STS_LOW_BIT  = 3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    AFM_MAG_OFF    = 3'b000,
    AFM_MAG_I0P5   = 3'b001,
    AFM_MAG_I2     = 3'b010,
    AFM_MAG_I10    = 3'b011,
    AFM_MAG_I50    = 3'b100,
    AFM_MAG_I200   = 3'b101,
    AFM_MAG_R10M   = 3'b110,
    AFM_MAG_RSVD   = 3'b111
  } afm_bias_mag_t;

  typedef struct packed {
    logic diffOver;
    logic outHigh;
    logic outLow;
  } afm_alarm_t;

  typedef struct packed {
    logic [3:0] posCode;
    logic [3:0] negCode;
    logic       tempSensor;
    logic       anaSupplyMon;
    logic       digSupplyMon;
  } afm_route_t;

  typedef struct packed {
    logic       enable;
    logic       onAux;
    logic       srcPos;
    logic       srcNeg;
    logic       resistor;
    logic [4:0] currentSel;
  } afm_bias_t;

endpackage : afm_pkg

// [src/afm_frontend_ctrl.sv]
// Front-end configuration and amplifier alarm capture logic
// Function
// R1 - Gain codes 000..101 select 1 to 32
// R2 - BBh in primary select routes temp sensor
// R3 - BBh in aux select routes temp sensor
// R4 - CCh selects analog supply monitor
// R5 - DDh selects digital supply monitor
// R6 - Host sets gain 1, amp, reference for temp
// R7 - Host sets gain 1, amp for supply
// R8 - Triggered alarms read as ones in status
// R9 - Differential overrange flags its conversion cycle
// R10 - Differential flag clears at next conversion
// R11 - High flag when output near positive supply
// R12 - Low flag when output near negative supply
// R13 - High and low flags clear next cycle
// R14 - Bias attaches to primary or aux
// R15 - Pull-up sources positive; pull-down reversed
// R16 - Bias magnitude: resistor or five currents
// R17 - Bypass connects inputs straight to modulator
// R18 - Primary select holds pos and neg nibbles
// R19 - Alarms sticky per cycle, moved at ready
`timescale 1ns/1ps

module afm_frontend_ctrl
  import afm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  // Conversion timing
  input  wire logic       convStart,
  input  wire logic       dataReady,
  // Comparator levels from the analog monitors
  input  wire logic       diffOverRaw,
  input  wire logic       outHighRaw,
  input  wire logic       outLowRaw,
  // Analog controls
  output afm_route_t      priRoute,
  output afm_route_t      auxRoute,
  output logic      [5:0] ampGain,
  output logic            gainCodeBad,
  output logic            ampBypass,
  output afm_bias_t       biasCtrl,
  // Status byte sent with conversion data
  output logic      [7:0] statusByte,
  output logic            statusValid
);

  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  function automatic afm_route_t decodeRoute(input logic [7:0] sel);
    afm_route_t r;
    r.posCode      = sel[AFM_POS_LSB +: 4];                      // R18
    r.negCode      = sel[AFM_NEG_LSB +: 4];                      // R18
    r.tempSensor   = (sel == AFM_SEL_TEMP);                      // R2
    r.anaSupplyMon = (sel == AFM_SEL_ANA_MON);                   // R4
    r.digSupplyMon = (sel == AFM_SEL_DIG_MON);                   // R5
    return r;
  endfunction : decodeRoute

  function automatic logic [5:0] decodeGain(input logic [2:0] code);
    logic [5:0] g;
    g = 6'h01;
    unique case (code)
      3'b000:  g = 6'h01;                                        // R1
      3'b001:  g = 6'h02;                                        // R1
      3'b010:  g = 6'h04;                                        // R1
      3'b011:  g = 6'h08;                                        // R1
      3'b100:  g = 6'h10;                                        // R1
      3'b101:  g = 6'h20;                                        // R1
      default: g = 6'h01;
    endcase
    return g;
  endfunction : decodeGain

  function automatic afm_bias_t decodeBias(input logic [7:0] cfg);
    afm_bias_t     b;
    afm_bias_mag_t mag;
    mag          = afm_bias_mag_t'(cfg[AFM_BIAS_MAG_LSB +: 3]);
    b.onAux      = cfg[AFM_BIAS_TGT_BIT];                        // R14
    b.resistor   = 1'b0;
    b.currentSel = 5'h00;
    unique case (mag)
      AFM_MAG_OFF:  b.currentSel = 5'h00;
      AFM_MAG_I0P5: b.currentSel = 5'h01;                        // R16
      AFM_MAG_I2:   b.currentSel = 5'h02;                        // R16
      AFM_MAG_I10:  b.currentSel = 5'h04;                        // R16
      AFM_MAG_I50:  b.currentSel = 5'h08;                        // R16
      AFM_MAG_I200: b.currentSel = 5'h10;                        // R16
      AFM_MAG_R10M: b.resistor   = 1'b1;                         // R16
      AFM_MAG_RSVD: b.currentSel = 5'h00;
    endcase
    b.enable = (b.currentSel != 5'h00) || b.resistor;
    // Pull-up sources into positive, sinks from negative
    b.srcPos = b.enable && !cfg[AFM_BIAS_POL_BIT];               // R15
    b.srcNeg = b.enable && cfg[AFM_BIAS_POL_BIT];                // R15
    return b;
  endfunction : decodeBias

  function automatic afm_alarm_t mergeAlarm(input afm_alarm_t held,
                                            input afm_alarm_t live);
    afm_alarm_t m;
    m.diffOver = held.diffOver | live.diffOver;                  // R9
    m.outHigh  = held.outHigh  | live.outHigh;                   // R11
    m.outLow   = held.outLow   | live.outLow;                    // R12
    return m;
  endfunction : mergeAlarm

  function automatic logic [7:0] packStatus(input afm_alarm_t a);
    logic [7:0] s;
    s                   = AFM_RST_STATUS;
    s[AFM_STS_DIFF_BIT] = a.diffOver;                            // R8
    s[AFM_STS_HIGH_BIT] = a.outHigh;                             // R8
    s[AFM_STS_LOW_BIT]  = a.outLow;                              // R8
    return s;
  endfunction : packStatus

  function automatic logic gainCodeOk(input logic [2:0] code);
    return (code <= AFM_GAIN_LAST);                              // R1
  endfunction : gainCodeOk

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] priSel_ff;
  logic [7:0] auxSel_ff;
  logic [7:0] gainCfg_ff;
  logic [7:0] biasCfg_ff;
  logic [7:0] nxt_priSel;
  logic [7:0] nxt_auxSel;
  logic [7:0] nxt_gainCfg;
  logic [7:0] nxt_biasCfg;

  always_comb begin
    nxt_priSel  = priSel_ff;
    nxt_auxSel  = auxSel_ff;
    nxt_gainCfg = gainCfg_ff;
    nxt_biasCfg = biasCfg_ff;
    if (regWrEn) begin
      unique case (regAddr)
        AFM_OFS_PRI_SEL:  nxt_priSel  = regWrData;               // R2
        AFM_OFS_AUX_SEL:  nxt_auxSel  = regWrData;               // R3
        AFM_OFS_GAIN_CFG: nxt_gainCfg = regWrData & AFM_GAIN_WR_MASK;
        AFM_OFS_BIAS_CFG: nxt_biasCfg = regWrData & AFM_BIAS_WR_MASK;
        default:          nxt_priSel  = priSel_ff;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      priSel_ff  <= AFM_RST_PRI_SEL;
      auxSel_ff  <= AFM_RST_AUX_SEL;
      gainCfg_ff <= AFM_RST_GAIN_CFG;
      biasCfg_ff <= AFM_RST_BIAS_CFG;
    end else begin
      priSel_ff  <= nxt_priSel;
      auxSel_ff  <= nxt_auxSel;
      gainCfg_ff <= nxt_gainCfg;
      biasCfg_ff <= nxt_biasCfg;
    end
  end

  // ---------------------------------------------------------------
  // Input routing and sensor bias outputs
  // ---------------------------------------------------------------
  afm_route_t priRoute_ff;
  afm_route_t auxRoute_ff;
  afm_bias_t  biasCtrl_ff;
  afm_route_t nxt_priRoute;
  afm_route_t nxt_auxRoute;
  afm_bias_t  nxt_biasCtrl;

  always_comb begin
    nxt_priRoute = decodeRoute(nxt_priSel);                      // R2
    nxt_auxRoute = decodeRoute(nxt_auxSel);                      // R3
    nxt_biasCtrl = decodeBias(nxt_biasCfg);                      // R14
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      priRoute_ff <= '0;
      auxRoute_ff <= '0;
      biasCtrl_ff <= '0;
    end else begin
      priRoute_ff <= nxt_priRoute;
      auxRoute_ff <= nxt_auxRoute;
      biasCtrl_ff <= nxt_biasCtrl;
    end
  end

  assign priRoute = priRoute_ff;
  assign auxRoute = auxRoute_ff;
  assign biasCtrl = biasCtrl_ff;

  // ---------------------------------------------------------------
  // Amplifier gain and bypass outputs
  // ---------------------------------------------------------------
  logic [5:0] ampGain_ff;
  logic       gainBad_ff;
  logic       bypass_ff;
  logic [5:0] nxt_ampGain;
  logic       nxt_gainBad;
  logic       nxt_bypass;

  always_comb begin
    nxt_ampGain = decodeGain(nxt_gainCfg[AFM_GAIN_LSB +: 3]);    // R1
    nxt_gainBad = !gainCodeOk(nxt_gainCfg[AFM_GAIN_LSB +: 3]);   // R1
    // Bypass routes the selected inputs to the modulator
    nxt_bypass  = nxt_gainCfg[AFM_BYPASS_BIT];                   // R17
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ampGain_ff <= AFM_RST_AMP_GAIN;
      gainBad_ff <= 1'b0;
      bypass_ff  <= 1'b0;
    end else begin
      ampGain_ff <= nxt_ampGain;
      gainBad_ff <= nxt_gainBad;
      bypass_ff  <= nxt_bypass;
    end
  end

  assign ampGain     = ampGain_ff;
  assign gainCodeBad = gainBad_ff;
  assign ampBypass   = bypass_ff;

  // ---------------------------------------------------------------
  // Comparator synchronisers
  // ---------------------------------------------------------------
  afm_alarm_t almMeta_ff;
  afm_alarm_t almSync_ff;
  afm_alarm_t nxt_almMeta;

  always_comb begin
    nxt_almMeta.diffOver = diffOverRaw;
    nxt_almMeta.outHigh  = outHighRaw;
    nxt_almMeta.outLow   = outLowRaw;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      almMeta_ff <= '0;
      almSync_ff <= '0;
    end else begin
      almMeta_ff <= nxt_almMeta;
      almSync_ff <= almMeta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Per-conversion sticky alarms
  // ---------------------------------------------------------------
  afm_alarm_t sticky_ff;
  afm_alarm_t nxt_sticky;

  always_comb begin
    // Start of conversion clears; a live alarm still sets
    nxt_sticky = convStart ? '0 : sticky_ff;                     // R10 R13
    nxt_sticky = mergeAlarm(nxt_sticky, almSync_ff);             // R19
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sticky_ff <= '0;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end

  // ---------------------------------------------------------------
  // Status byte sent with conversion data
  // ---------------------------------------------------------------
  afm_alarm_t captured;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic       stsValid_ff;
  logic       nxt_stsValid;

  always_comb begin
    // Include the alarm seen in the ready cycle itself
    captured     = mergeAlarm(sticky_ff, almSync_ff);            // R19
    nxt_status   = status_ff;
    nxt_stsValid = 1'b0;
    if (dataReady) begin
      nxt_status   = packStatus(captured);                       // R8 R19
      nxt_stsValid = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_ff   <= AFM_RST_STATUS;
      stsValid_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      stsValid_ff <= nxt_stsValid;
    end
  end

  assign statusByte  = status_ff;
  assign statusValid = stsValid_ff;

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------
  logic [7:0] rdData_ff;
  logic       rdValid_ff;
  logic [7:0] nxt_rdData;
  logic       nxt_rdValid;

  always_comb begin
    nxt_rdData  = rdData_ff;
    nxt_rdValid = regRdEn;
    if (regRdEn) begin
      unique case (regAddr)
        AFM_OFS_PRI_SEL:  nxt_rdData = priSel_ff;                // R18
        AFM_OFS_AUX_SEL:  nxt_rdData = auxSel_ff;
        AFM_OFS_GAIN_CFG: nxt_rdData = gainCfg_ff;
        AFM_OFS_BIAS_CFG: nxt_rdData = biasCfg_ff;
        AFM_OFS_STATUS:   nxt_rdData = status_ff;                // R8
        default:          nxt_rdData = AFM_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_ff  <= AFM_RST_RD_DATA;
      rdValid_ff <= 1'b0;
    end else begin
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
    end
  end

  assign regRdData  = rdData_ff;
  assign regRdValid = rdValid_ff;

endmodule : afm_frontend_ctrl

// [testbench/afm_frontend_ctrl_sva.sv]
// Checker for register decode and status timing
`timescale 1ns/1ps
module afm_frontend_ctrl_chk
  import afm_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regRdValid,
  input wire logic       dataReady,
  input wire afm_route_t priRoute,
  input wire afm_route_t auxRoute,
  input wire logic [5:0] ampGain,
  input wire logic       ampBypass,
  input wire logic [7:0] statusByte,
  input wire logic       statusValid
);
  // ----
  // Assertions
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic pw, aw, gw;
  assign pw = regWrEn && regAddr == AFM_OFS_PRI_SEL;
  assign aw = regWrEn && regAddr == AFM_OFS_AUX_SEL;
  assign gw = regWrEn && regAddr == AFM_OFS_GAIN_CFG;
  chk_rd_answer: assert property (regRdValid == $past(regRdEn))
    else $error("read answer timing wrong");
  chk_sts_answer: assert property (statusValid == $past(dataReady))
    else $error("status valid timing wrong");
  chk_temp_pri: assert property (pw && regWrData == AFM_SEL_TEMP
    |=> priRoute.tempSensor) else $error("primary temp route missing");
  chk_temp_aux: assert property (aw && regWrData == AFM_SEL_TEMP
    |=> auxRoute.tempSensor) else $error("aux temp route missing");
  chk_ana_mon: assert property (pw && regWrData == AFM_SEL_ANA_MON
    |=> priRoute.anaSupplyMon && !priRoute.tempSensor)
    else $error("analog monitor route wrong");
  chk_dig_mon: assert property (aw && regWrData == AFM_SEL_DIG_MON
    |=> auxRoute.digSupplyMon && !auxRoute.anaSupplyMon)
    else $error("digital monitor route wrong");
  chk_gain_max: assert property (gw && regWrData[2:0] == 3'h5
    |=> ampGain == 6'h20) else $error("gain 32 not decoded");
  chk_bypass_bit: assert property (gw
    |=> ampBypass == $past(regWrData[7])) else $error("bypass wrong");
  chk_sel_nibbles: assert property (pw
    |=> {priRoute.negCode, priRoute.posCode} == $past(regWrData))
    else $error("select nibbles wrong");
  chk_sts_spare: assert property (statusValid
    |-> (statusByte & 8'hf1) == 8'h00) else $error("spare status set");
  chk_sts_hold: assert property (!dataReady |=> $stable(statusByte))
    else $error("status changed without ready");
  cover property (statusValid && statusByte[AFM_STS_DIFF_BIT]);
  cover property (statusValid && statusByte[AFM_STS_LOW_BIT]);
  cover property (pw && regWrData == AFM_SEL_TEMP);
endmodule : afm_frontend_ctrl_chk

bind afm_frontend_ctrl afm_frontend_ctrl_chk u_chk (
  .core_clk(core_clk), .rst(rst), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
  .regRdValid(regRdValid), .dataReady(dataReady),
  .priRoute(priRoute), .auxRoute(auxRoute), .ampGain(ampGain),
  .ampBypass(ampBypass), .statusByte(statusByte),
  .statusValid(statusValid)
);

// [testbench/afm_host_model.sv]
// Host controller model issuing register cycles
`timescale 1ns/1ps
module afm_host_model
  import afm_pkg::*;
(
  input  wire logic       core_clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData
);
  // ----
  // Register cycles
  // ----
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
  endtask : rd
  // Gain 1, amplifier in, then route the monitor
  task automatic meas_setup(input logic aux, input logic [7:0] sel);
    wr(AFM_OFS_GAIN_CFG, 8'h00);
    wr(aux ? AFM_OFS_AUX_SEL : AFM_OFS_PRI_SEL, sel);
  endtask : meas_setup
endmodule : afm_host_model

// [testbench/tb.sv]
// Self-checking bench for the front-end control block
`timescale 1ns/1ps
module tb;
  import afm_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       regWrEn, regRdEn, regRdValid, gainCodeBad, ampBypass;
  logic [7:0] regAddr, regWrData, regRdData, statusByte, d;
  logic       convStart, dataReady, statusValid;
  logic       diffOverRaw, outHighRaw, outLowRaw;
  logic [5:0] ampGain;
  afm_route_t priRoute, auxRoute, r;
  afm_bias_t  biasCtrl;
  logic [2:0] m;
  int         bad_count = 0;
  int         n_compared = 0;
  int         seed = 67949;
  int         cyc = 0;
  logic [7:0] rdQ[$];
  logic [7:0] stQ[$];
  logic [7:0] ofs[6] = '{8'h06, 8'h16, 8'h08, 8'h09, 8'h0a, 8'h33};
  logic [7:0] msk[5] = '{8'hff, 8'hff, 8'h87, 8'h1f, 8'h00};
  logic [7:0] sel[3] = '{8'hbb, 8'hcc, 8'hdd};
  always #50 core_clk = ~core_clk;
  afm_host_model u_host (.core_clk(core_clk), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
  afm_frontend_ctrl u_dut (.core_clk(core_clk), .rst(rst),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .convStart(convStart),
    .dataReady(dataReady), .diffOverRaw(diffOverRaw),
    .outHighRaw(outHighRaw), .outLowRaw(outLowRaw),
    .priRoute(priRoute), .auxRoute(auxRoute), .ampGain(ampGain),
    .gainCodeBad(gainCodeBad), .ampBypass(ampBypass),
    .biasCtrl(biasCtrl), .statusByte(statusByte),
    .statusValid(statusValid));
  // ----
  // Checking and closing
  // ----
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    u_host.rd(a);
  endtask : rdx
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (regRdValid === 1'b1)
      chk(regRdData, rdQ.size() > 0 ? rdQ.pop_front() : 8'hxx);
    if (statusValid === 1'b1)
      chk(statusByte, stQ.size() > 0 ? stQ.pop_front() : 8'hxx);
    if (cyc > 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // One conversion with alarm levels a = {diff, high, low}
  task automatic conv(input logic [2:0] a);
    @(posedge core_clk) convStart <= 1'b1;
    @(posedge core_clk) convStart <= 1'b0;
    {diffOverRaw, outHighRaw, outLowRaw} <= a;
    repeat (3) @(posedge core_clk);
    {diffOverRaw, outHighRaw, outLowRaw} <= 3'h0;
    repeat (4) @(posedge core_clk);
    stQ.push_back({4'h0, a[0], a[1], a[2], 1'b0});
    dataReady <= 1'b1;
    @(posedge core_clk) dataReady <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : conv
  // ----
  // Main sequence
  // ----
  initial begin
    {convStart, dataReady, diffOverRaw, outHighRaw, outLowRaw} = 5'h00;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ofs[i]) rdx(ofs[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      u_host.wr(ofs[i], d);
      rdx(ofs[i], d & msk[i]);
    end
    for (int g = 0; g < 8; g++) begin
      u_host.wr(AFM_OFS_GAIN_CFG, {g[0], 4'h0, g[2:0]});
      #1;
      chk(ampGain, g < 6 ? 6'h01 << g : 6'h01);
      chk(gainCodeBad, g > 5);
      chk(ampBypass, g[0]);
    end
    for (int i = 0; i < 6; i++) begin
      u_host.meas_setup(i > 2, sel[i % 3]);
      #1;
      r = (i > 2) ? auxRoute : priRoute;
      chk({r.tempSensor, r.anaSupplyMon, r.digSupplyMon},
          3'b100 >> (i % 3));
      chk({r.negCode, r.posCode}, sel[i % 3]);
    end
    for (int b = 0; b < 32; b++) begin
      d = 8'($random(seed));
      d = {d[7:5], b[4:0]};
      m = b[4:2];
      u_host.wr(AFM_OFS_BIAS_CFG, d);
      #1;
      chk({biasCtrl.enable, biasCtrl.resistor, biasCtrl.currentSel},
          {m > 0 && m < 7, m == 6,
           (m > 0 && m < 6) ? 5'h01 << (m - 1) : 5'h00});
      if (m > 0 && m < 7) begin
        chk(biasCtrl.onAux, b[0]);
        chk({biasCtrl.srcPos, biasCtrl.srcNeg},
            b[1] ? 2'b01 : 2'b10);
      end
    end
    for (int k = 1; k < 8; k++) begin
      conv(k[2:0]);
      conv(3'h0);
    end
    conv(3'h7);
    rdx(AFM_OFS_STATUS, 8'h0e);
    repeat (3) @(posedge core_clk);
    chk(rdQ.size() + stQ.size(), 0);
    tally_and_finish();
  end
endmodule : tb
